// ---- src/svd_dma_regs.sv ----
// DMA pointer and control registers for sound, video and cursor channels
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module svd_dma_regs
  import svd_pkg::*;
(
  input  wire logic                      clock_i,
  input  wire logic                      rst_b_i,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [8:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // DMA engine side
  input  wire logic                      sound_fetch_done_i,
  input  wire logic                      cursor_fetch_done_i,
  input  wire logic                      upper_fetch_done_i,
  input  wire logic                      lower_fetch_done_i,
  input  wire logic                      flyback_i,
  output logic [31:0]                    sound_fetch_addr_o,
  output logic                           sound_active_o,
  output logic                           sound_switch_o,
  output logic [31:0]                    cursor_fetch_addr_o,
  output logic [31:0]                    upper_fetch_addr_o,
  output logic [31:0]                    lower_fetch_addr_o,
  output logic                           video_active_o,
  output logic                           dual_panel_o,
  output logic                           cpu_irq_request_n_o
);
  import svd_pkg::*;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Pointer field as a read word, bits 3 to 0 and above 28 zero
  function automatic logic [31:0] ptr_word(input logic [PTR_W-1:0] p);
    return {3'h0, p, 4'h0};
  endfunction

  logic [PTR_W-1:0]  sound_current_a_r, sound_current_b_r;
  logic [OFS_W-1:0]  sound_end_ofs_a_r, sound_end_ofs_b_r;
  logic              stop_a_r, stop_b_r, last_a_r, last_b_r;
  logic              sound_en_r, sound_halt_r;
  logic [2:0]        sound_state_r;
  logic [PTR_W-1:0]  cursor_current_r, cursor_init_r;
  logic [PTR_W-1:0]  upper_current_r, lower_current_r;
  logic [PTR_W-1:0]  upper_init_r, lower_init_r, frame_start_r;
  logic [VEND_W-1:0] frame_end_r;
  logic              video_en_r, dual_r, irq_mask_r, switch_r;
  logic              ack_r;
  logic [31:0]       rd_data_r;

  // Bus decode; a write lands on the edge where the master sees ack
  wire        wr_now  = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  wire        rd_take = wb_cyc_i & wb_stb_i & ~ack_r;
  wire [31:0] wdata   = wb_dat_i;
  wire        wr_cur_a  = wr_now & (wb_adr_i == SOUND_CURRENT_A_OFS);
  wire        wr_end_a  = wr_now & (wb_adr_i == SOUND_END_A_OFS);
  wire        wr_cur_b  = wr_now & (wb_adr_i == SOUND_CURRENT_B_OFS);
  wire        wr_end_b  = wr_now & (wb_adr_i == SOUND_END_B_OFS);
  wire        wr_sctl   = wr_now & (wb_adr_i == SOUND_CTRL_OFS);
  wire        wr_ccur   = wr_now & (wb_adr_i == CURSOR_CURRENT_OFS);
  wire        wr_cinit  = wr_now & (wb_adr_i == CURSOR_INIT_OFS);
  wire        wr_lcur   = wr_now & (wb_adr_i == LOWER_CURRENT_OFS);
  wire        wr_ucur   = wr_now & (wb_adr_i == UPPER_CURRENT_OFS);
  wire        wr_fend   = wr_now & (wb_adr_i == FRAME_END_OFS);
  wire        wr_fstart = wr_now & (wb_adr_i == FRAME_START_OFS);
  wire        wr_uinit  = wr_now & (wb_adr_i == UPPER_INIT_OFS);
  wire        wr_vctl   = wr_now & (wb_adr_i == VIDEO_CTRL_OFS);
  wire        wr_linit  = wr_now & (wb_adr_i == LOWER_INIT_OFS);
  wire        wr_mask   = wr_now & (wb_adr_i == IRQ_MASK_OFS);

  // Merged write words per register; low nibble dropped on pointers
  wire [31:0] m_cur_a  = wmerge(ptr_word(sound_current_a_r), wdata, wb_sel_i);
  wire [31:0] m_cur_b  = wmerge(ptr_word(sound_current_b_r), wdata, wb_sel_i);
  wire [31:0] m_end_a  = wmerge({stop_a_r, last_a_r, 18'h0, sound_end_ofs_a_r, 4'h0},
                                wdata, wb_sel_i);
  wire [31:0] m_end_b  = wmerge({stop_b_r, last_b_r, 18'h0, sound_end_ofs_b_r, 4'h0},
                                wdata, wb_sel_i);
  wire [31:0] m_ccur   = wmerge(ptr_word(cursor_current_r), wdata, wb_sel_i);
  wire [31:0] m_cinit  = wmerge(ptr_word(cursor_init_r), wdata, wb_sel_i);
  wire [31:0] m_lcur   = wmerge(ptr_word(lower_current_r), wdata, wb_sel_i);
  wire [31:0] m_ucur   = wmerge(ptr_word(upper_current_r), wdata, wb_sel_i);
  wire [31:0] m_uinit  = wmerge(ptr_word(upper_init_r), wdata, wb_sel_i);
  wire [31:0] m_linit  = wmerge(ptr_word(lower_init_r), wdata, wb_sel_i);
  wire [31:0] m_fstart = wmerge(ptr_word(frame_start_r), wdata, wb_sel_i);
  wire [31:0] m_fend   = wmerge({8'h0, frame_end_r, 4'h0}, wdata, wb_sel_i);
  wire [31:0] m_sctl   = wmerge({24'h0, 2'h0, sound_en_r, 5'h0}, wdata, wb_sel_i);
  wire [31:0] m_vctl   = wmerge({24'h0, dual_r, 1'b0, video_en_r, 5'h0}, wdata,
                                wb_sel_i);
  wire [31:0] m_mask   = wmerge({27'h0, irq_mask_r, 4'h0}, wdata, wb_sel_i);

  // Sound channel: active pair selected by the buffer state bit
  wire              buf_b     = sound_state_r[ST_BUF];
  wire [PTR_W-1:0]  act_ptr   = buf_b ? sound_current_b_r : sound_current_a_r;
  wire [OFS_W-1:0]  act_end   = buf_b ? sound_end_ofs_b_r : sound_end_ofs_a_r;
  wire              act_stop  = buf_b ? stop_b_r : stop_a_r;
  wire              act_last  = buf_b ? last_b_r : last_a_r;
  wire              sound_go  = sound_en_r & ~sound_halt_r;
  wire              s_access  = sound_go & sound_fetch_done_i;
  // End compare on in-page offset only; last bit marks a single transfer
  wire              at_end    = (act_ptr[OFS_W-1:0] == act_end) | act_last;
  wire              s_wrap    = s_access & at_end & ~act_stop;
  wire              s_stop    = s_access & at_end & act_stop;
  wire [PTR_W-1:0]  act_inc   = act_ptr + PTR_ONE;
  wire              clr_force = wr_sctl & wb_sel_i[0] & wdata[CTRL_CLR_BIT];
  // Refill of either end register acknowledges the buffer interrupt
  wire              irq_ack   = wr_end_a | wr_end_b;
  wire              irq_pend  = sound_state_r[ST_IRQ];
  wire              irq_req   = irq_pend & irq_mask_r;

  // Video and cursor: fetches only count while enabled
  wire              vid_go    = video_en_r;
  wire              c_access  = vid_go & cursor_fetch_done_i;
  wire              u_access  = vid_go & upper_fetch_done_i;
  wire              l_access  = vid_go & dual_r & lower_fetch_done_i;
  wire              u_at_end  = upper_current_r[VEND_W-1:0] == frame_end_r;
  wire              l_at_end  = lower_current_r[VEND_W-1:0] == frame_end_r;
  wire              fly_load  = vid_go & flyback_i;

  // Wishbone ack: one cycle after the strobe, then dropped
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
  end

  // Read mux; unmapped offsets read as zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      SOUND_CURRENT_A_OFS: rd_mux = ptr_word(sound_current_a_r);
      SOUND_CURRENT_B_OFS: rd_mux = ptr_word(sound_current_b_r);
      SOUND_END_A_OFS:     rd_mux = {stop_a_r, last_a_r, 18'h0, sound_end_ofs_a_r,
                                     4'h0};
      SOUND_END_B_OFS:     rd_mux = {stop_b_r, last_b_r, 18'h0, sound_end_ofs_b_r,
                                     4'h0};
      SOUND_CTRL_OFS:      rd_mux = {24'h0, 2'h0, sound_en_r, CTRL_LOW_READ};
      SOUND_STATE_OFS:     rd_mux = {29'h0, sound_state_r};
      CURSOR_CURRENT_OFS:  rd_mux = ptr_word(cursor_current_r);
      CURSOR_INIT_OFS:     rd_mux = ptr_word(cursor_init_r);
      LOWER_CURRENT_OFS:   rd_mux = ptr_word(lower_current_r);
      UPPER_CURRENT_OFS:   rd_mux = ptr_word(upper_current_r);
      FRAME_END_OFS:       rd_mux = {8'h0, frame_end_r, 4'h0};
      FRAME_START_OFS:     rd_mux = ptr_word(frame_start_r);
      UPPER_INIT_OFS:      rd_mux = ptr_word(upper_init_r);
      LOWER_INIT_OFS:      rd_mux = ptr_word(lower_init_r);
      VIDEO_CTRL_OFS:      rd_mux = {24'h0, dual_r, 1'b1, video_en_r, CTRL_LOW_READ};
      IRQ_STATE_OFS:       rd_mux = {27'h0, irq_pend, 4'h0};
      IRQ_REQ_OFS:         rd_mux = {27'h0, irq_req, 4'h0};
      IRQ_MASK_OFS:        rd_mux = {27'h0, irq_mask_r, 4'h0};
      default:             rd_mux = 32'h0;
    endcase
  end

  // Read data captured as ack rises
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rd_data_r <= 32'h0;
    else if (rd_take)
      rd_data_r <= rd_mux;
  end

  // Sound pair A; DMA keeps advancing A only while A is active
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      sound_current_a_r <= '0;
      sound_end_ofs_a_r <= '0;
      stop_a_r          <= 1'b0;
      last_a_r          <= 1'b0;
    end
    else
    begin
      if (s_access && !buf_b)
        sound_current_a_r <= act_inc;
      else if (wr_cur_a)
        sound_current_a_r <= m_cur_a[PTR_HI:PTR_LO];
      if (wr_end_a)
      begin
        stop_a_r          <= m_end_a[END_STOP_BIT];
        last_a_r          <= m_end_a[END_LAST_BIT];
        sound_end_ofs_a_r <= m_end_a[OFS_HI:PTR_LO];
      end
    end
  end

  // Sound pair B, same as A
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      sound_current_b_r <= '0;
      sound_end_ofs_b_r <= '0;
      stop_b_r          <= 1'b0;
      last_b_r          <= 1'b0;
    end
    else
    begin
      if (s_access && buf_b)
        sound_current_b_r <= act_inc;
      else if (wr_cur_b)
        sound_current_b_r <= m_cur_b[PTR_HI:PTR_LO];
      if (wr_end_b)
      begin
        stop_b_r          <= m_end_b[END_STOP_BIT];
        last_b_r          <= m_end_b[END_LAST_BIT];
        sound_end_ofs_b_r <= m_end_b[OFS_HI:PTR_LO];
      end
    end
  end

  // Sound state: a hardware set wins over a software acknowledge
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      sound_state_r <= SOUND_STATE_RST;
      sound_en_r    <= 1'b0;
      sound_halt_r  <= 1'b0;
      switch_r      <= 1'b0;
    end
    else
    begin
      switch_r <= s_wrap;
      if (wr_sctl && wb_sel_i[0])
        sound_en_r <= m_sctl[CTRL_EN_BIT];
      // Stop at end wins over a control write in the same cycle
      if (s_stop)
        sound_halt_r <= 1'b1;
      else if (wr_sctl && wb_sel_i[0])
        sound_halt_r <= 1'b0;
      if (clr_force)
      begin
        sound_state_r[ST_OVR] <= 1'b1;
        sound_state_r[ST_IRQ] <= 1'b1;
        // A wrap in the same cycle must still swap pairs, or the active pair runs past its end
        if (s_wrap)
          sound_state_r[ST_BUF] <= ~buf_b;
      end
      else if (s_wrap)
      begin
        // A second wrap before software refilled is an overrun
        sound_state_r[ST_OVR] <= sound_state_r[ST_OVR] | irq_pend;
        sound_state_r[ST_IRQ] <= 1'b1;
        sound_state_r[ST_BUF] <= ~buf_b;
      end
      else if (irq_ack)
      begin
        sound_state_r[ST_OVR] <= 1'b0;
        sound_state_r[ST_IRQ] <= 1'b0;
      end
    end
  end

  // Cursor pointers; flyback reload takes priority over a fetch
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cursor_current_r <= '0;
      cursor_init_r    <= '0;
    end
    else
    begin
      if (fly_load)
        cursor_current_r <= cursor_init_r;
      else if (c_access)
        cursor_current_r <= cursor_current_r + PTR_ONE;
      else if (wr_ccur)
        cursor_current_r <= m_ccur[PTR_HI:PTR_LO];
      if (wr_cinit)
        cursor_init_r <= m_cinit[PTR_HI:PTR_LO];
    end
  end

  // Video pointers; past the frame end the fetch wraps to the start
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      upper_current_r <= '0;
      lower_current_r <= '0;
    end
    else
    begin
      if (fly_load)
        upper_current_r <= upper_init_r;
      else if (u_access)
        upper_current_r <= u_at_end ? frame_start_r : upper_current_r + PTR_ONE;
      else if (wr_ucur)
        upper_current_r <= m_ucur[PTR_HI:PTR_LO];
      if (fly_load && dual_r)
        lower_current_r <= lower_init_r;
      else if (l_access)
        lower_current_r <= l_at_end ? frame_start_r : lower_current_r + PTR_ONE;
      else if (wr_lcur)
        lower_current_r <= m_lcur[PTR_HI:PTR_LO];
    end
  end

  // Video setup registers and interrupt mask
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      upper_init_r  <= '0;
      lower_init_r  <= '0;
      frame_start_r <= '0;
      frame_end_r   <= '0;
      video_en_r    <= 1'b0;
      dual_r        <= 1'b0;
      irq_mask_r    <= 1'b0;
    end
    else
    begin
      if (wr_uinit)
        upper_init_r <= m_uinit[PTR_HI:PTR_LO];
      if (wr_linit)
        lower_init_r <= m_linit[PTR_HI:PTR_LO];
      if (wr_fstart)
        frame_start_r <= m_fstart[PTR_HI:PTR_LO];
      if (wr_fend)
        frame_end_r <= m_fend[VEND_HI:PTR_LO];
      if (wr_vctl)
      begin
        video_en_r <= m_vctl[CTRL_EN_BIT];
        dual_r     <= m_vctl[CTRL_DUAL_BIT];
      end
      if (wr_mask)
        irq_mask_r <= m_mask[IRQ_BIT];
    end
  end

  // Outputs
  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = rd_data_r;
  assign sound_fetch_addr_o  = ptr_word(act_ptr);
  assign sound_active_o      = sound_go;
  assign sound_switch_o      = switch_r;
  assign cursor_fetch_addr_o = ptr_word(cursor_current_r);
  assign upper_fetch_addr_o  = ptr_word(upper_current_r);
  assign lower_fetch_addr_o  = ptr_word(lower_current_r);
  assign video_active_o      = video_en_r;
  assign dual_panel_o        = dual_r;
  assign cpu_irq_request_n_o = ~irq_req;

  // Checks on the block's own behaviour
  sound_advance_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_access && !s_wrap && !clr_force |=>
      sound_fetch_addr_o == ($past(sound_fetch_addr_o) + 32'h10))
    else $error("sound pointer did not advance by a quad word");
  sound_nibble_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    sound_fetch_addr_o[3:0] == 4'h0 && upper_fetch_addr_o[3:0] == 4'h0)
    else $error("pointer low nibble not zero");
  stop_halt_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_stop |=> !sound_active_o ##1 (!sound_active_o || $past(wr_sctl)))
    else $error("channel kept running after stop at end");
  buffer_switch_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_wrap |=> sound_switch_o && (sound_state_r[ST_BUF] != $past(buf_b)))
    else $error("buffer pair not switched at end");
  clear_force_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    clr_force |=> sound_state_r[ST_OVR] && sound_state_r[ST_IRQ])
    else $error("clear did not force overrun state");
  ctrl_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    rd_take && wb_adr_i == SOUND_CTRL_OFS |=> wb_ack_o && wb_dat_o[4:0] == 5'h10
      && wb_dat_o[7:6] == 2'h0)
    else $error("sound control fixed bits wrong");
  flyback_load_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    fly_load |=> cursor_current_r == $past(cursor_init_r))
    else $error("cursor not reloaded at flyback");
  irq_line_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cpu_irq_request_n_o == !(sound_state_r[ST_IRQ] && irq_mask_r))
    else $error("interrupt line does not follow masked status");
  video_gate_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !video_en_r && !flyback_i && !wr_ucur |=> $stable(upper_current_r))
    else $error("upper pointer moved while video disabled");
  ack_once_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

endmodule // svd_dma_regs

// ---- src/svd_pkg.sv ----
// Package with register map, field positions and reset values of the DMA pointer block
package svd_pkg;

  // Register byte offsets
  localparam logic [8:0] SOUND_CURRENT_A_OFS   = 9'h180;
  localparam logic [8:0] SOUND_END_A_OFS       = 9'h184;
  localparam logic [8:0] SOUND_CURRENT_B_OFS   = 9'h188;
  localparam logic [8:0] SOUND_END_B_OFS       = 9'h18c;
  localparam logic [8:0] SOUND_CTRL_OFS        = 9'h190;
  localparam logic [8:0] SOUND_STATE_OFS       = 9'h194;
  localparam logic [8:0] CURSOR_CURRENT_OFS    = 9'h1c0;
  localparam logic [8:0] CURSOR_INIT_OFS       = 9'h1c4;
  localparam logic [8:0] LOWER_CURRENT_OFS     = 9'h1c8;
  localparam logic [8:0] UPPER_CURRENT_OFS     = 9'h1d0;
  localparam logic [8:0] FRAME_END_OFS         = 9'h1d4;
  localparam logic [8:0] FRAME_START_OFS       = 9'h1d8;
  localparam logic [8:0] UPPER_INIT_OFS        = 9'h1dc;
  localparam logic [8:0] VIDEO_CTRL_OFS        = 9'h1e0;
  localparam logic [8:0] LOWER_INIT_OFS        = 9'h1e8;
  localparam logic [8:0] IRQ_STATE_OFS         = 9'h1f0;
  localparam logic [8:0] IRQ_REQ_OFS           = 9'h1f4;
  localparam logic [8:0] IRQ_MASK_OFS          = 9'h1f8;

  // Field positions
  localparam int PTR_HI        = 28;
  localparam int PTR_LO        = 4;
  localparam int PTR_W         = 25;
  localparam int VEND_HI       = 23;
  localparam int VEND_W        = 20;
  localparam int OFS_HI        = 11;
  localparam int OFS_W         = 8;
  localparam int END_STOP_BIT  = 31;
  localparam int END_LAST_BIT  = 30;
  localparam int CTRL_CLR_BIT  = 7;
  localparam int CTRL_DUAL_BIT = 7;
  localparam int CTRL_EN_BIT   = 5;
  localparam int IRQ_BIT       = 4;

  // Sound state bit positions: overrun, interrupt request, buffer B active
  localparam int ST_OVR = 2;
  localparam int ST_IRQ = 1;
  localparam int ST_BUF = 0;

  // Values after reset and fixed read values
  localparam logic [2:0] SOUND_STATE_RST  = 3'h6;
  localparam logic [4:0] CTRL_LOW_READ    = 5'h10;
  localparam logic [PTR_W-1:0] PTR_ONE    = 25'h0000001;

endpackage

// ---- test/svd_dma_regs_test.sv ----
// Register and fetch pointer tests for the DMA pointer block
`timescale 1ns/1ps
module svd_dma_regs_test;
  import svd_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sw_seen = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [31:0] dat = 32'h0, q, rdat, s_adr, c_adr, u_adr, l_adr;
  logic [4:0]  go = 5'h00;
  logic [3:0]  sel = 4'hf;
  logic        ack, s_act, s_sw, v_act, dual, irq_n, s_dn, c_dn, u_dn, l_dn, fly;
  int          errors = 0, samples_checked = 0, cycles = 0, n;

  always #10 clock_i = ~clock_i;

  // Cycle ceiling and sticky record of the one-cycle switch pulse
  always @(posedge clock_i)
  begin
    cycles++;
    if (s_sw === 1'b1) sw_seen <= 1'b1;
    if (cycles == 4000) begin errors++; print_verdict(); end
  end

  svd_dma_regs u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sound_fetch_done_i(s_dn), .cursor_fetch_done_i(c_dn),
    .upper_fetch_done_i(u_dn), .lower_fetch_done_i(l_dn), .flyback_i(fly),
    .sound_fetch_addr_o(s_adr), .sound_active_o(s_act), .sound_switch_o(s_sw),
    .cursor_fetch_addr_o(c_adr), .upper_fetch_addr_o(u_adr), .lower_fetch_addr_o(l_adr),
    .video_active_o(v_act), .dual_panel_o(dual), .cpu_irq_request_n_o(irq_n));

  svd_mem_model u_mem (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go),
    .sound_active_i(s_act), .video_active_i(v_act), .sound_done_o(s_dn),
    .cursor_done_o(c_dn), .upper_done_o(u_dn), .lower_done_o(l_dn), .flyback_o(fly));

  task print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  // Classic cycle: held until ack is sampled high, released at that edge
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, s};
    n = 0;
    do begin @(posedge clock_i); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) errors++;
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task rd(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk($sformatf("reg %h", a), q & m, e);
  endtask

  // One request to the memory model, then outputs left to settle
  task fetch(input logic [4:0] g);
    @(posedge clock_i);
    go <= g;
    @(posedge clock_i);
    go <= 5'h00;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(SOUND_STATE_OFS, 32'hff, 32'h6);
    rd(SOUND_CTRL_OFS, 32'hff, 32'h10);
    wr(SOUND_CURRENT_A_OFS, 32'hffff_ffff);
    rd(SOUND_CURRENT_A_OFS, 32'h1fff_ffff, 32'h1fff_fff0);
    wr(SOUND_END_A_OFS, 32'h8000_0ff7);
    rd(SOUND_END_A_OFS, 32'hc000_0ff0, 32'h8000_0ff0);
    // Pair A runs on to pair B, which halts at its end; last bit kept clear
    wr(SOUND_CURRENT_A_OFS, 32'h0000_1000);
    wr(SOUND_END_A_OFS, 32'h0000_0030);
    wr(SOUND_CURRENT_B_OFS, 32'h0000_2000);
    wr(SOUND_END_B_OFS, 32'h8000_0020);
    wr(IRQ_MASK_OFS, 32'h10);
    rd(SOUND_STATE_OFS, 32'h7, 32'h0);
    chk("irq_n", irq_n, 32'h1);
    wr(SOUND_CTRL_OFS, 32'h20);
    fetch(5'h01);
    fetch(5'h01);
    chk("sound_addr", s_adr, 32'h1020);
    for (int i = 0; i < 8 && s_adr !== 32'h2000; i++) fetch(5'h01);
    chk("sound_addr", s_adr, 32'h2000);
    chk("switch", sw_seen, 32'h1);
    rd(SOUND_STATE_OFS, 32'h7, 32'h3);
    chk("irq_n", irq_n, 32'h0);
    rd(IRQ_STATE_OFS, 32'h10, 32'h10);
    rd(IRQ_REQ_OFS, 32'h10, 32'h10);
    wr(SOUND_CURRENT_A_OFS, 32'h0000_3000);
    rd(SOUND_CURRENT_A_OFS, 32'h1fff_ffff, 32'h3000);
    for (int i = 0; i < 8 && s_act === 1'b1; i++) fetch(5'h01);
    chk("active", s_act, 32'h0);
    wr(SOUND_CTRL_OFS, 32'hff);
    rd(SOUND_CTRL_OFS, 32'hff, 32'h30);
    rd(SOUND_STATE_OFS, 32'h7, 32'h7);
    // Video and cursor pointers reload on flyback and step per fetch
    wr(VIDEO_CTRL_OFS, 32'ha0);
    rd(VIDEO_CTRL_OFS, 32'hff, 32'hf0);
    wr(CURSOR_INIT_OFS, 32'h0000_400f);
    rd(CURSOR_INIT_OFS, 32'h1fff_ffff, 32'h4000);
    wr(UPPER_INIT_OFS, 32'h6000);
    wr(LOWER_INIT_OFS, 32'h8000);
    wr(FRAME_START_OFS, 32'hffff_ffff);
    rd(FRAME_START_OFS, 32'h1fff_ffff, 32'h1fff_fff0);
    wr(FRAME_END_OFS, 32'hffff_ffff);
    rd(FRAME_END_OFS, 32'h00ff_ffff, 32'h00ff_fff0);
    fetch(5'h10);
    chk("cursor", c_adr, 32'h4000);
    chk("lower", l_adr, 32'h8000);
    chk("upper", u_adr, 32'h6000);
    chk("video", v_act, 32'h1);
    chk("dual", dual, 32'h1);
    fetch(5'h0e);
    chk("cursor", c_adr, 32'h4010);
    chk("lower", l_adr, 32'h8010);
    chk("upper", u_adr, 32'h6010);
    rd(UPPER_CURRENT_OFS, 32'h1fff_ffff, 32'h6010);
    // Disabled video ignores flyback and fetches; byte lanes merge on write
    wr(VIDEO_CTRL_OFS, 32'h0);
    fetch(5'h1e);
    chk("cursor", c_adr, 32'h4010);
    chk("video", v_act, 32'h0);
    bus(1'b1, CURSOR_INIT_OFS, 32'hffff_ffff, 4'h2);
    rd(CURSOR_INIT_OFS, 32'h1fff_ffff, 32'h0000_ff00);
    rd(9'h1fc, 32'hffff_ffff, 32'h0);
    print_verdict();
  end
endmodule // svd_dma_regs_test

// ---- test/svd_mem_model.sv ----
// Memory-side model answering the DMA channel fetch requests
`timescale 1ns/1ps
module svd_mem_model
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic [4:0] go_i,
  input  wire logic       sound_active_i,
  input  wire logic       video_active_i,
  output logic            sound_done_o,
  output logic            cursor_done_o,
  output logic            upper_done_o,
  output logic            lower_done_o,
  output logic            flyback_o
);
  // One finished access per request; no channel gets an answer while its active input is low, lower is answered without dual panel
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      {sound_done_o, cursor_done_o, upper_done_o, lower_done_o, flyback_o} <= 5'h00;
    else
    begin
      sound_done_o  <= go_i[0] & sound_active_i;
      cursor_done_o <= go_i[1] & video_active_i;
      upper_done_o  <= go_i[2] & video_active_i;
      lower_done_o  <= go_i[3] & video_active_i;
      flyback_o     <= go_i[4];
    end
  end
endmodule // svd_mem_model
